// ### rtl/zce_pkg.sv
`default_nettype none
package zce_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_MASK = 8'h08;
	localparam int BIT_EN = 7;
	localparam int BIT_LEVEL = 5;
	localparam int BIT_POL = 4;
	localparam int BIT_RISE = 1;
	localparam int BIT_FALL = 0;
	localparam int BIT_FLAG = 0;
	localparam logic RST_EN = 1'h0;
	localparam logic RST_POL = 1'h0;
	localparam logic RST_RISE = 1'h0;
	localparam logic RST_FALL = 1'h0;
	localparam logic RST_FLAG = 1'h0;
	localparam logic RST_MASK = 1'h0;
	localparam logic [31:0] RST_RDATA = 32'h0000_0000;
	localparam int SYNC_STAGES = 2;
endpackage
`default_nettype wire

// ### rtl/zce_evt_if.sv
`default_nettype none
interface zce_evt_if;
	logic level;
	logic rise;
	logic fall;
	modport src (
		output level,
		output rise,
		output fall
	);
	modport dst (
		input level,
		input rise,
		input fall
	);
endinterface
`default_nettype wire

// ### rtl/zce_sync.sv
`default_nettype none
module zce_sync #(
	parameter int WIDTH = 1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	import zce_pkg::*;

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	if (WIDTH < 1) begin : g_bad_width
		$error("zce_sync: WIDTH must be at least 1");
	end

	// First stage feeds only the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;
endmodule
`default_nettype wire

// ### rtl/zce_edge.sv
`default_nettype none
module zce_edge (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic sink_sync,
	input wire logic pol,
	zce_evt_if.src evt
);
	import zce_pkg::*;

	logic level_q;
	logic prev_q;
	logic valid_q;

	// Polarity applied before edge detection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level_q <= 1'h0;
			prev_q <= 1'h0;
			valid_q <= 1'h0;
		end else begin
			level_q <= sink_sync ^ pol;
			prev_q <= level_q;
			valid_q <= 1'h1;
		end
	end

	// No edge until history is valid
	assign evt.level = level_q;
	assign evt.rise = valid_q & level_q & ~prev_q;
	assign evt.fall = valid_q & ~level_q & prev_q;
endmodule
`default_nettype wire

// ### rtl/zce_top.sv
`default_nettype none
module zce_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [zce_pkg::ADDR_W-1:0] paddr,
	input wire logic [zce_pkg::DATA_W-1:0] pwdata,
	output logic [zce_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic cross_default_off_fuse,
	input wire logic cross_sink_raw,
	input wire logic pin_route_out,
	input wire logic pin_route_oe,
	output logic pad_out,
	output logic pad_oe,
	output logic drive_enable,
	output logic cross_logic_output,
	output logic cross_event_irq
);
	import zce_pkg::*;

	// ********************
	// Declarations
	// ********************
	logic en_q;
	logic pol_q;
	logic rise_en_q;
	logic fall_en_q;
	logic flag_q;
	logic flag_d;
	logic mask_q;
	logic [DATA_W-1:0] rdata_q;
	logic [DATA_W-1:0] rdata_d;
	logic setup;
	logic access;
	logic wr;
	logic rd;
	logic hit_ctrl;
	logic hit_status;
	logic hit_mask;
	logic mapped;
	logic wr_ctrl;
	logic wr_mask;
	logic rd_clr;
	logic pol_change;
	logic edge_set;
	logic flag_set;
	logic active;
	logic sink_sync;
	logic [DATA_W-1:0] ctrl_view;

	zce_evt_if evt();

	// ********************
	// Input conditioning
	// ********************
	zce_sync #(
		.WIDTH(SYNC_STAGES - 1)
	) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(cross_sink_raw),
		.sync_out(sink_sync)
	);

	zce_edge u_edge (
		.pclk(pclk),
		.presetn(presetn),
		.sink_sync(sink_sync),
		.pol(pol_q),
		.evt(evt.src)
	);

	// ********************
	// Bus decode
	// ********************
	assign setup = psel & ~penable;
	assign access = psel & penable;
	assign wr = access & pwrite;
	assign rd = access & ~pwrite;

	always_comb begin
		hit_ctrl = 1'h0;
		hit_status = 1'h0;
		hit_mask = 1'h0;
		if (paddr == OFF_CTRL) begin
			hit_ctrl = 1'h1;
		end else if (paddr == OFF_STATUS) begin
			hit_status = 1'h1;
		end else if (paddr == OFF_MASK) begin
			hit_mask = 1'h1;
		end
	end

	assign mapped = hit_ctrl | hit_status | hit_mask;
	assign pready = 1'h1;
	assign pslverr = access & ~mapped;
	assign wr_ctrl = wr & hit_ctrl;
	assign wr_mask = wr & hit_mask;
	assign rd_clr = rd & hit_status;

	// ********************
	// Control register
	// ********************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_q <= RST_EN;
			pol_q <= RST_POL;
			rise_en_q <= RST_RISE;
			fall_en_q <= RST_FALL;
		end else if (wr_ctrl) begin
			// Bits 6, 5, 3 and 2 are dropped
			en_q <= pwdata[BIT_EN];
			pol_q <= pwdata[BIT_POL];
			rise_en_q <= pwdata[BIT_RISE];
			fall_en_q <= pwdata[BIT_FALL];
		end
	end

	always_comb begin
		ctrl_view = '0;
		ctrl_view[BIT_EN] = en_q;
		ctrl_view[BIT_LEVEL] = evt.level;
		ctrl_view[BIT_POL] = pol_q;
		ctrl_view[BIT_RISE] = rise_en_q;
		ctrl_view[BIT_FALL] = fall_en_q;
	end

	// ********************
	// Mask register
	// ********************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_q <= RST_MASK;
		end else if (wr_mask) begin
			mask_q <= pwdata[BIT_FLAG];
		end
	end

	// ********************
	// Read data
	// ********************
	always_comb begin
		rdata_d = rdata_q;
		if (setup && !pwrite) begin
			rdata_d = '0;
			if (hit_ctrl) begin
				rdata_d = ctrl_view;
			end else if (hit_status) begin
				rdata_d[BIT_FLAG] = flag_q;
			end else if (hit_mask) begin
				rdata_d[BIT_FLAG] = mask_q;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_q <= RST_RDATA;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign prdata = rdata_q;

	// ********************
	// Pin ownership
	// ********************
	assign active = ~cross_default_off_fuse | en_q;
	assign drive_enable = active;
	assign pad_oe = active ? 1'h0 : pin_route_oe;
	assign pad_out = active ? 1'h0 : pin_route_out;

	// ********************
	// Event flag
	// ********************
	// Runs on the free clock, no sleep gating
	assign pol_change = wr_ctrl & (pwdata[BIT_POL] != pol_q);
	assign edge_set = (evt.rise & rise_en_q) | (evt.fall & fall_en_q);
	assign flag_set = edge_set | pol_change;
	assign flag_d = flag_set | (flag_q & ~rd_clr);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_q <= RST_FLAG;
		end else begin
			flag_q <= flag_d;
		end
	end

	// ********************
	// Outputs
	// ********************
	assign cross_logic_output = evt.level;
	assign cross_event_irq = flag_q & mask_q;

	// ********************
	// Assertions
	// ********************
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_pin_takeover: assert property (
		(cross_default_off_fuse && en_q) |-> (drive_enable && !pad_oe)
	) else $error("pin not taken while enabled");

	a_pin_release: assert property (
		(cross_default_off_fuse && !en_q)
			|-> (!drive_enable && pad_oe == pin_route_oe && pad_out == pin_route_out)
	) else $error("pin not released while disabled");

	a_level_plain: assert property (
		!$past(pol_q) |-> cross_logic_output == $past(sink_sync)
	) else $error("level wrong with polarity clear");

	a_level_inv: assert property (
		$past(pol_q) |-> cross_logic_output == !$past(sink_sync)
	) else $error("level wrong with polarity set");

	a_rise_sets: assert property (
		(evt.rise && rise_en_q) |=> flag_q
	) else $error("rising edge did not set flag");

	a_fall_sets: assert property (
		(evt.fall && fall_en_q) |=> flag_q
	) else $error("falling edge did not set flag");

	a_quiet_hold: assert property (
		(!flag_q && !pol_change && !(evt.rise && rise_en_q) && !(evt.fall && fall_en_q))
			|=> !flag_q
	) else $error("flag set without cause");

	a_fuse_active: assert property (
		!cross_default_off_fuse |-> drive_enable
	) else $error("fuse clear but circuit inactive");

	a_en_ignored: assert property (
		(!cross_default_off_fuse && wr_ctrl && !pwdata[BIT_EN])
			##1 !cross_default_off_fuse |-> drive_enable
	) else $error("enable write changed operation");

	a_reserved_zero: assert property (
		(rd && hit_ctrl) |-> (prdata[6] == 1'h0 && prdata[3:2] == 2'h0)
	) else $error("reserved bits not zero");

	a_pol_event: assert property (
		pol_change |=> flag_q
	) else $error("polarity change gave no event");

	a_set_wins: assert property (
		(flag_set && rd_clr) |=> flag_q
	) else $error("clear beat a simultaneous set");

	a_read_clears: assert property (
		(rd_clr && !flag_set) |=> !flag_q
	) else $error("status read did not clear flag");

	a_one_event: assert property (
		evt.rise |-> (!evt.fall ##1 !evt.rise)
	) else $error("transition gave more than one event");

	a_irq_level: assert property (
		(flag_q && mask_q && !rd_clr && !wr_mask) |=> cross_event_irq
	) else $error("interrupt level dropped");

	a_irq_masked: assert property (
		!mask_q |-> !cross_event_irq
	) else $error("interrupt raised while masked");

	a_release_drive: assert property (
		!drive_enable |-> (pad_oe == pin_route_oe && pad_out == pin_route_out)
	) else $error("routing not passed through when inactive");

	a_active_quiet: assert property (
		drive_enable |-> (!pad_oe && !pad_out)
	) else $error("digital driver on while circuit owns pin");

	a_level_ro: assert property (
		(rd && hit_ctrl) |-> prdata[BIT_LEVEL] == $past(evt.level)
	) else $error("level bit not read from detector");

	a_flag_kept: assert property (
		(flag_q && !rd_clr) |=> flag_q
	) else $error("flag cleared without a status read");

	a_level_out: assert property (
		cross_logic_output == evt.level
	) else $error("level output differs from detector");
endmodule
`default_nettype wire

// ### dv/zce_cmp_model.sv
`default_nettype none
module zce_cmp_model (
	input wire logic drive_enable,
	input wire logic applied_high,
	output logic cross_sink_raw
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************
	// Analog comparator
	// ****************
	// Starts sourcing so the level is known before the first read
	initial cross_sink_raw = 1'b0;
	// Sinks while the applied level is above reference; settles a few ns late
	always @(applied_high or drive_enable) begin
		cross_sink_raw <= #3 applied_high;
	end
endmodule
`default_nettype wire

// ### dv/zce_tb.sv
`default_nettype none
module tb;
	import zce_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin bad_count++; \
		$display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fuse = 1;
	logic [ADDR_W-1:0] paddr = '0;
	logic [DATA_W-1:0] pwdata = '0, prdata;
	logic pready, pslverr, raw, r_out = 1, r_oe = 1, pad_out, pad_oe, drv, lvl, irq, appl = 0;
	int bad_count = 0, samples_checked = 0;
	// ****************
	// Clock, DUT, far side
	// ****************
	initial forever #10 pclk = ~pclk;
	zce_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cross_default_off_fuse(fuse), .cross_sink_raw(raw), .pin_route_out(r_out),
		.pin_route_oe(r_oe), .pad_out(pad_out), .pad_oe(pad_oe), .drive_enable(drv),
		.cross_logic_output(lvl), .cross_event_irq(irq));
	zce_cmp_model u_cmp (.drive_enable(drv), .applied_high(appl), .cross_sink_raw(raw));
	// ****************
	// Bus tasks
	// ****************
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		xfer(1, a, d, r, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		logic [31:0] r;
		logic e;
		xfer(0, a, 32'h0, r, e);
		`CHK(r, x)
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic end_of_test();
		if (bad_count == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// ****************
	// Tests
	// ****************
	initial begin
		logic [31:0] r;
		logic e;
		wt(2);
		presetn <= 1;
		wt(1);
		`CHK({drv, pad_oe, pad_out}, 3'b011)
		rd(OFF_CTRL, 32'h0000_0000);
		wr(OFF_CTRL, 32'hFFFF_FFFF);
		wt(4);
		`CHK({drv, pad_oe, pad_out}, 3'b100)
		rd(OFF_CTRL, 32'h0000_00B3);
		rd(OFF_STATUS, 32'h0000_0001);
		rd(OFF_STATUS, 32'h0000_0000);
		wr(OFF_CTRL, 32'h0000_0082);
		wt(4);
		rd(OFF_STATUS, 32'h0000_0001);
		appl <= 1;
		wt(8);
		`CHK(lvl, 1'b1)
		rd(OFF_STATUS, 32'h0000_0001);
		appl <= 0;
		wt(8);
		rd(OFF_STATUS, 32'h0000_0000);
		wr(OFF_CTRL, 32'h0000_0081);
		appl <= 1;
		wt(8);
		rd(OFF_STATUS, 32'h0000_0000);
		wr(OFF_MASK, 32'h0000_0001);
		rd(OFF_MASK, 32'h0000_0001);
		appl <= 0;
		wt(8);
		`CHK(irq, 1'b1)
		rd(OFF_STATUS, 32'h0000_0001);
		wt(1);
		`CHK(irq, 1'b0)
		wr(OFF_CTRL, 32'h0000_0090);
		wt(6);
		`CHK(lvl, 1'b1)
		rd(OFF_CTRL, 32'h0000_00B0);
		xfer(0, 8'h0C, 32'h0, r, e);
		`CHK({r, e}, 33'h0_0000_0001)
		wr(OFF_CTRL, 32'h0000_0000);
		wt(1);
		`CHK({drv, pad_oe}, 2'b01)
		presetn <= 0;
		fuse <= 0;
		wt(2);
		`CHK(drv, 1'b1)
		presetn <= 1;
		wr(OFF_CTRL, 32'h0000_0000);
		wt(1);
		`CHK({drv, pad_oe}, 2'b10)
		end_of_test();
	end
	initial begin
		#200us;
		bad_count++;
		end_of_test();
	end
endmodule
`default_nettype wire
